// ==== src/rqcc_pkg.sv ====
// Package for the receiver quadrature clock control register bank.
// Assumes an 8-bit parallel register port with a 6-bit address.
package rqcc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] RQCC_ADDR_TRIM = 6'h1D;
    localparam logic [5:0] RQCC_ADDR_PATH = 6'h1E;
    localparam logic [5:0] RQCC_ADDR_QCLK = 6'h1F;

    // ------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] RQCC_TRIM_RST = 8'h00;
    localparam logic [7:0] RQCC_PATH_RST = 8'h41;
    localparam logic [7:0] RQCC_RSVD_MASK = 8'h3C;
    localparam logic [4:0] RQCC_DELAY_ZERO = 5'h00;
    localparam logic [4:0] RQCC_DELAY_MAX = 5'h1F;
    localparam int RQCC_PH_W = 7;

    typedef enum logic [1:0] {
        RQCC_SRC_LOW = 2'b00,
        RQCC_SRC_DEMOD = 2'b01,
        RQCC_SRC_SUBC = 2'b10,
        RQCC_SRC_BASE = 2'b11
    } rqcc_src_t;

    typedef struct packed {
        logic receiver_clock_phase_select;
        logic receiver_auto_power_switch;
        logic [3:0] reserved;
        rqcc_src_t decoder_input_select;
    } rqcc_path_t;

    typedef struct packed {
        logic quadrature_calibration_disable;
        logic reserved;
        logic [4:0] quadrature_delay_count;
    } rqcc_qclk_t;

    typedef enum logic [1:0] {
        RQCC_CAL_IDLE = 2'b00,
        RQCC_CAL_STEP = 2'b01,
        RQCC_CAL_DONE = 2'b10
    } rqcc_cal_t;

endpackage

// ==== src/rqcc_regs.sv ====
// Receiver path and quadrature clock control register bank.
// Assumes host strobes (wr_en, rd_en) synchronous to mclk and a measured
// phase of the delay line supplied by the analog delay as a count.
`timescale 1ns/1ps

module rqcc_regs
    import rqcc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [5:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    input wire logic rx_active,
    input wire logic rx_done,
    input wire logic clk_i_phase,
    input wire logic clk_q_phase,
    input wire logic [6:0] delay_phase,
    input wire logic [6:0] quarter_phase,
    input wire logic demod_bit,
    input wire logic external_manchester_input_pin,
    output logic decoder_in,
    output logic receiver_clock,
    output logic receiver_power_on,
    output logic [4:0] quadrature_delay_count,
    output logic calibrating
);

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    logic external_manchester_input_pin_s1_r, external_manchester_input_pin_s2_r;
    always_ff @(posedge mclk) begin
        external_manchester_input_pin_s1_r <= external_manchester_input_pin;
        external_manchester_input_pin_s2_r <= external_manchester_input_pin_s1_r;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] trim_r, trim_nxt;
    rqcc_path_t path_r, path_nxt;
    rqcc_qclk_t qclk_r, qclk_nxt;
    rqcc_cal_t cal_r, cal_nxt;
    logic [7:0] rd_data_nxt;
    logic wr_trim, wr_path, wr_qclk;

    assign wr_trim = wr_en && (addr == RQCC_ADDR_TRIM);
    assign wr_path = wr_en && (addr == RQCC_ADDR_PATH);
    assign wr_qclk = wr_en && (addr == RQCC_ADDR_QCLK);

    // Delay line lags by over half a period when above two quarters.
    logic over_half;
    assign over_half = delay_phase > {quarter_phase[5:0], 1'b0};

    always_comb begin
        trim_nxt = trim_r;
        path_nxt = path_r;
        qclk_nxt = qclk_r;
        cal_nxt = cal_r;
        if (wr_trim) begin
            trim_nxt = wr_data;
        end
        if (wr_path) begin
            path_nxt = rqcc_path_t'(wr_data);
        end
        if (wr_qclk) begin
            qclk_nxt = rqcc_qclk_t'(wr_data[6:0]);
        end
        unique case (cal_r)
            RQCC_CAL_IDLE: begin
                if (rx_done && !qclk_r.quadrature_calibration_disable) begin
                    cal_nxt = RQCC_CAL_STEP;
                    qclk_nxt.quadrature_delay_count = RQCC_DELAY_ZERO;
                end
            end
            RQCC_CAL_STEP: begin
                // Walk the delay line until it spans a quarter period.
                if (delay_phase >= quarter_phase ||
                    qclk_r.quadrature_delay_count == RQCC_DELAY_MAX) begin
                    cal_nxt = RQCC_CAL_DONE;
                end else begin
                    qclk_nxt.quadrature_delay_count =
                        qclk_r.quadrature_delay_count + 5'h01;
                end
            end
            RQCC_CAL_DONE: begin
                cal_nxt = RQCC_CAL_IDLE;
            end
            default: begin
                cal_nxt = RQCC_CAL_IDLE;
            end
        endcase
        rd_data_nxt = 8'h00;
        if (rd_en) begin
            unique case (addr)
                RQCC_ADDR_TRIM: rd_data_nxt = trim_r;
                RQCC_ADDR_PATH: rd_data_nxt = path_r;
                RQCC_ADDR_QCLK: rd_data_nxt = {over_half, qclk_r};
                default: rd_data_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            trim_r <= RQCC_TRIM_RST;
            path_r <= rqcc_path_t'(RQCC_PATH_RST);
            qclk_r <= {2'b00, RQCC_DELAY_ZERO};
            cal_r <= RQCC_CAL_STEP;
            rd_data <= 8'h00;
        end else begin
            trim_r <= trim_nxt;
            path_r <= path_nxt;
            qclk_r <= qclk_nxt;
            cal_r <= cal_nxt;
            rd_data <= rd_data_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        unique case (path_r.decoder_input_select)
            RQCC_SRC_LOW: decoder_in = 1'b0;
            RQCC_SRC_DEMOD: decoder_in = demod_bit;
            RQCC_SRC_SUBC: decoder_in = external_manchester_input_pin_s2_r;
            RQCC_SRC_BASE: decoder_in = external_manchester_input_pin_s2_r;
        endcase
    end

    // The quadrature input is the in-phase clock through the delay line.
    assign receiver_clock = path_r.receiver_clock_phase_select ?
        clk_i_phase : clk_q_phase;
    assign receiver_power_on =
        !path_r.receiver_auto_power_switch || rx_active;
    assign quadrature_delay_count = qclk_r.quadrature_delay_count;
    assign calibrating = (cal_r == RQCC_CAL_STEP);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence path_write_s;
        wr_path && !rd_en;
    endsequence

    trim_reset_a: assert property ($fell(rst) |->
        $past(trim_r) == RQCC_TRIM_RST)
        else $error("trim not zero after reset");
    path_reset_a: assert property ($fell(rst) |->
        $past(path_r) == RQCC_PATH_RST)
        else $error("path control not 41h after reset");
    clk_select_a: assert property (path_write_s |=>
        receiver_clock == ($past(wr_data[7]) ? clk_i_phase : clk_q_phase))
        else $error("receiver clock selection wrong");
    power_auto_a: assert property (!path_r.receiver_auto_power_switch
        |-> receiver_power_on)
        else $error("receiver powered down while auto off");
    src_low_a: assert property (path_r.decoder_input_select == RQCC_SRC_LOW
        |-> !decoder_in)
        else $error("decoder input not low");
    half_flag_a: assert property (rd_en && addr == RQCC_ADDR_QCLK
        |=> rd_data[7] == $past(over_half))
        else $error("half period flag wrong");
    cal_start_a: assert property (cal_r == RQCC_CAL_IDLE && rx_done &&
        !qclk_r.quadrature_calibration_disable && !wr_qclk
        |=> calibrating)
        else $error("calibration not started");
    cal_off_a: assert property (cal_r == RQCC_CAL_IDLE &&
        qclk_r.quadrature_calibration_disable |=> !calibrating)
        else $error("calibration ran while disabled");
    delay_wr_a: assert property (wr_qclk && cal_r != RQCC_CAL_STEP &&
        !(cal_r == RQCC_CAL_IDLE && rx_done &&
        !qclk_r.quadrature_calibration_disable)
        |=> quadrature_delay_count == $past(wr_data[4:0]))
        else $error("delay count write lost");
    top_reset_a: assert property ($fell(rst) |->
        $past(qclk_r.quadrature_calibration_disable) == 1'b0)
        else $error("calibration disable not zero after reset");
    cal_bound_a: assert property ($rose(calibrating) |->
        ##[1:33] !calibrating)
        else $error("calibration did not finish");

    // ------------------------------------------------------------
    // Register and read port checks
    // ------------------------------------------------------------
    sequence read_trim_s;
        rd_en && addr == RQCC_ADDR_TRIM;
    endsequence

    sequence read_path_s;
        rd_en && addr == RQCC_ADDR_PATH;
    endsequence

    sequence read_unmapped_s;
        rd_en && addr != RQCC_ADDR_TRIM && addr != RQCC_ADDR_PATH &&
            addr != RQCC_ADDR_QCLK;
    endsequence

    trim_hold_a: assert property (
        !wr_trim |=> $stable(trim_r))
        else $error("trim changed without a write");
    trim_read_a: assert property (
        read_trim_s |=> rd_data == $past(trim_r))
        else $error("trim read data wrong");
    path_load_a: assert property (
        wr_path |=> path_r == $past(wr_data))
        else $error("path control write lost");
    path_read_a: assert property (
        read_path_s |=> rd_data == $past(path_r))
        else $error("path control read data wrong");
    read_idle_a: assert property (
        !rd_en |=> rd_data == 8'h00)
        else $error("read data not cleared after a read");
    read_unmap_a: assert property (
        read_unmapped_s |=> rd_data == 8'h00)
        else $error("unmapped read data not zero");

    // ------------------------------------------------------------
    // Receiver output checks
    // ------------------------------------------------------------
    power_rx_a: assert property (
        path_r.receiver_auto_power_switch |->
            receiver_power_on == rx_active)
        else $error("receiver power does not follow reception");
    src_demod_a: assert property (
        path_r.decoder_input_select == RQCC_SRC_DEMOD |->
            decoder_in == demod_bit)
        else $error("decoder input not from demodulator");
    src_pin_a: assert property (
        path_r.decoder_input_select[1] |-> decoder_in == external_manchester_input_pin_s2_r)
        else $error("decoder input not from pin");
    pin_sync_a: assert property (
        external_manchester_input_pin_s2_r == $past(external_manchester_input_pin, 2))
        else $error("pin synchroniser depth wrong");

    // ------------------------------------------------------------
    // Calibration checks
    // ------------------------------------------------------------
    sequence cal_begin_s;
        cal_r == RQCC_CAL_IDLE && rx_done &&
            !qclk_r.quadrature_calibration_disable;
    endsequence

    sequence cal_walk_s;
        calibrating && delay_phase < quarter_phase &&
            quadrature_delay_count != RQCC_DELAY_MAX;
    endsequence

    sequence cal_reach_s;
        calibrating && (delay_phase >= quarter_phase ||
            quadrature_delay_count == RQCC_DELAY_MAX);
    endsequence

    sequence cal_finish_s;
        cal_r == RQCC_CAL_DONE ##1 cal_r == RQCC_CAL_IDLE;
    endsequence

    cal_zero_a: assert property (
        cal_begin_s |=> calibrating &&
            quadrature_delay_count == RQCC_DELAY_ZERO)
        else $error("calibration did not restart from zero");
    cal_step_a: assert property (
        cal_walk_s |=> quadrature_delay_count ==
            $past(quadrature_delay_count) + 5'h01)
        else $error("calibration did not step the delay count");
    cal_stop_a: assert property (
        cal_reach_s |=> cal_finish_s)
        else $error("calibration did not stop at a quarter period");
    cal_keep_a: assert property (
        calibrating && !wr_qclk && (delay_phase >= quarter_phase ||
            quadrature_delay_count == RQCC_DELAY_MAX) |=>
            $stable(quadrature_delay_count))
        else $error("final delay count not kept");
    delay_hold_a: assert property (
        cal_r == RQCC_CAL_IDLE && !rx_done && !wr_qclk |=>
            $stable(quadrature_delay_count))
        else $error("delay count changed while idle");
    qclk_load_a: assert property (
        wr_qclk && cal_r == RQCC_CAL_IDLE && !rx_done |=>
            qclk_r == $past(wr_data[6:0]))
        else $error("quadrature control write lost");

endmodule

// ==== verification/rqcc_host.sv ====
// Host microprocessor model for the register bank's parallel port.
// Assumes the bank takes its strobes at the rising edge of mclk.
`timescale 1ns/1ps
module rqcc_host
    import rqcc_pkg::*;
(
    input wire logic mclk,
    output logic [5:0] addr,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);
    initial begin
        addr = 6'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wr_data = 8'h00;
    end
    // Released lines show the inverse of the last value.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == RQCC_ADDR_PATH) v = d & ~RQCC_RSVD_MASK;
        if (a == RQCC_ADDR_QCLK) v[5] = 1'b0;
        if (a == RQCC_ADDR_TRIM) v = RQCC_TRIM_RST;
        @(posedge mclk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        addr <= ~a;
        wr_data <= ~v;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        addr <= ~a;
        #1 d = rd_data;
    endtask
endmodule

// ==== verification/rqcc_regs_tb.sv ====
// Self-checking bench for the receiver quadrature clock control bank.
// Assumes the host model drives the port; a delay line model is here.
`timescale 1ns/1ps
module rqcc_regs_tb import rqcc_pkg::*;;
    typedef struct packed {
        logic [7:0] path;
        logic [4:0] in;
        logic [2:0] exp;
    } rqcc_row_t;
    logic mclk, rst, rx_active, rx_done, clk_i_phase, clk_q_phase;
    logic demod_bit, pin, wr_en, rd_en, decoder_in, receiver_clock;
    logic receiver_power_on, calibrating;
    logic [5:0] addr;
    logic [7:0] wr_data, rd_data, rv;
    logic [6:0] quarter_phase, delay_phase;
    logic [4:0] dcount;
    int bad_count, n_compared;
    rqcc_row_t rows [6] = '{'{8'h80, 5'b10110, 3'b101},
        '{8'h00, 5'b10110, 3'b001}, '{8'h41, 5'b01100, 3'b110},
        '{8'h42, 5'b10011, 3'b011}, '{8'h83, 5'b10100, 3'b101},
        '{8'hC1, 5'b00001, 3'b001}};
    // Each delay element adds two phase units.
    assign delay_phase = {1'b0, dcount, 1'b0};
    rqcc_host i_host (.mclk, .addr, .wr_en, .rd_en, .wr_data, .rd_data);
    rqcc_regs i_dut (.mclk, .rst, .addr, .wr_en, .rd_en, .wr_data,
        .rd_data, .rx_active, .rx_done, .clk_i_phase, .clk_q_phase,
        .delay_phase, .quarter_phase, .demod_bit,
        .external_manchester_input_pin(pin), .decoder_in, .receiver_clock,
        .receiver_power_on, .quadrature_delay_count(dcount), .calibrating);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic rx_pulse;
        @(posedge mclk);
        rx_done <= 1'b1;
        @(posedge mclk);
        rx_done <= 1'b0;
        #1;
    endtask
    task automatic wait_cal;
        int n;
        n = 0;
        while (calibrating !== 1'b0 && n < 60) begin
            @(posedge mclk);
            n++;
        end
        if (n == 60) bad_count++;
    endtask
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        #(4000 * 40);
        bad_count++;
        report_and_stop;
    end
    initial begin
        {rst, rx_active, rx_done, clk_i_phase, clk_q_phase} = 5'h1_0;
        {demod_bit, pin} = 2'h0;
        rst = 1'b1;
        quarter_phase = 7'h0A;
        bad_count = 0;
        n_compared = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        i_host.rd(RQCC_ADDR_TRIM, rv);
        check(rv, RQCC_TRIM_RST);
        i_host.rd(RQCC_ADDR_PATH, rv);
        check(rv, RQCC_PATH_RST);
        wait_cal;
        i_host.rd(RQCC_ADDR_QCLK, rv);
        check(rv, 8'h05);
        check({rv[7:5], 5'h00}, 8'h00);
        foreach (rows[k]) begin
            @(posedge mclk);
            {clk_i_phase, clk_q_phase, demod_bit, pin, rx_active} <=
                rows[k].in;
            i_host.wr(RQCC_ADDR_PATH, rows[k].path);
            i_host.rd(RQCC_ADDR_PATH, rv);
            check(rv, rows[k].path);
            check({receiver_clock, decoder_in, receiver_power_on},
                rows[k].exp);
        end
        // Calibration off: a host count survives a reception.
        i_host.wr(RQCC_ADDR_QCLK, 8'hDF);
        rx_pulse;
        check({7'h00, calibrating}, 8'h00);
        i_host.rd(RQCC_ADDR_QCLK, rv);
        check(rv, 8'hDF);
        i_host.wr(RQCC_ADDR_QCLK, 8'h00);
        rx_pulse;
        check({7'h00, calibrating}, 8'h01);
        wait_cal;
        i_host.rd(RQCC_ADDR_QCLK, rv);
        check(rv, 8'h05);
        i_host.rd(6'h20, rv);
        check(rv, 8'h00);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        i_host.rd(RQCC_ADDR_PATH, rv);
        check(rv, RQCC_PATH_RST);
        i_host.rd(RQCC_ADDR_QCLK, rv);
        check({rv[7:5], 5'h00}, 8'h00);
        report_and_stop;
    end
endmodule
